// ### rtl/dfsc_regs.vh
// Purpose: constants of the serial link configuration block
// Assumes: register index = word address, byte address = 4 * index
// Notes: included by the top module only
`ifndef DFSC_REGS_VH
`define DFSC_REGS_VH
// register indices
`define DFSC_IX_ADDR  12'he00
`define DFSC_IX_POL   12'he01
`define DFSC_IX_COMS  12'he03
`define DFSC_IX_FLDS  12'he04
`define DFSC_IX_CAPP  12'he0a
`define DFSC_IX_CBR   12'he0b
`define DFSC_IX_SBR   12'he50
`define DFSC_IX_FRM   12'he51
`define DFSC_IX_DLY   12'he52
`define DFSC_IX_TMO   12'he53
`define DFSC_IX_WORD  12'he54
`define DFSC_IX_SVER  12'he5a
`define DFSC_IX_CVER  12'he5c
`define DFSC_IX_MON1  12'he61
`define DFSC_IX_MON2  12'he62
`define DFSC_IX_STAT  12'he70
// reset values
`define DFSC_RST_ADDR 7'h01
`define DFSC_RST_POL  8'h01
`define DFSC_RST_COMS 1'h1
`define DFSC_RST_FLDS 1'h0
`define DFSC_RST_CAPP 1'h0
`define DFSC_RST_CBR  3'h5
`define DFSC_RST_SBR  4'h9
`define DFSC_RST_FRM  2'h3
`define DFSC_RST_DLY  5'h00
`define DFSC_RST_TMO  10'h000
`define DFSC_RST_WORD 1'h1
`define DFSC_RST_VER  16'h0000
// limits
`define DFSC_MAX_ADDR 7'h7f
`define DFSC_MAX_SBR  4'h9
`define DFSC_MAX_DLY  5'h14
`define DFSC_MAX_TMO  10'h258
`define DFSC_POL_DEFER 8'hff
`define DFSC_POL_MAX  8'h04
// status bit positions
`define DFSC_ST_TMO   0
`define DFSC_ST_OVR   1
`define DFSC_ST_PAR   2
`define DFSC_ST_FRM   3
// timing
`define DFSC_CLK_NS   25
`define DFSC_MS_NS    1000000
`define DFSC_CLK_HZ   40000000
`define DFSC_GAP_BITS 6'h20
// serial bit rates, bit/s
`define DFSC_B0 300
`define DFSC_B1 600
`define DFSC_B2 1200
`define DFSC_B3 2400
`define DFSC_B4 4800
`define DFSC_B5 9600
`define DFSC_B6 19200
`define DFSC_B7 38400
`define DFSC_B8 57600
`define DFSC_B9 115200
`endif

// ### rtl/dfsc_top.v
// Purpose: serial link configuration registers with station filter
// Assumes: APB master, one clock, stop flag from drive core
// Notes: a frame ends after a line gap of DFSC_GAP_BITS bit times
// Summary of operation
// - station address 1..127, applied at stop
// - bit-rate code picks ten serial rates
// - framing code picks parity and stop bits
// - reply waits configured 0..20 ms
// - link timeout 0..600 ms, immediate
// - word order selects 32-bit half order
// - CAN rate code, 6 and 7 both 1M
// - CAN application layer chosen at stop
// - save policy decodes to save controls
// - commissioning writes saved when flag set
// - fieldbus save flag decides saving only under policy DFSC_POL_DEFER
// - version words read-only, writes refused
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "dfsc_regs.vh"
module dfsc_top #(
   parameter CLK_HZ    = `DFSC_CLK_HZ,
   parameter MS_CYC    = `DFSC_MS_NS / `DFSC_CLK_NS,
   parameter [15:0] SER_VER = `DFSC_RST_VER, // arbitrary value
   parameter [15:0] CAN_VER = `DFSC_RST_VER  // arbitrary value
) (
   input  wire        CLK_I,
   input  wire        SRST_I,
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [15:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   input  wire        DRIVE_STOPPED_I,
   input  wire        RXD_I,
   output reg         TXD_O,
   output reg  [7:0]  RX_DATA_O,
   output reg         RX_VALID_O,
   input  wire        RX_READY_I,
   input  wire [7:0]  TX_DATA_I,
   input  wire        TX_VALID_I,
   output reg         TX_READY_O,
   output reg         LINK_TIMEOUT_O,
   output reg         WORD_LOW_FIRST_O,
   output reg  [6:0]  STATION_ADDR_O,
   output reg  [9:0]  CAN_KBPS_O,
   output reg         CAN_ENH_O,
   output reg         SAVE_PARAM_O,
   output reg         SAVE_DICT_O,
   output reg         SAVE_PRE_OP_O,
   output reg         COMM_SAVE_O
);
   localparam S_IDLE = 3'd0, S_START = 3'd1, S_DATA = 3'd2;
   localparam S_PAR  = 3'd3, S_STOP  = 3'd4;

   // software-visible configuration
   reg [6:0]  addr_reg;     // station address as written
   reg [7:0]  pol_reg;      // save policy
   reg        coms_reg;     // commissioning save flag
   reg        flds_reg;     // fieldbus save flag
   reg        capp_reg;     // CAN layer as written
   reg [2:0]  cbr_reg;      // CAN rate as written
   reg [3:0]  sbr_reg;      // serial rate code
   reg [1:0]  frm_reg;      // framing code
   reg [4:0]  dly_reg;      // reply delay, ms
   reg [9:0]  tmo_reg;      // link timeout, ms
   reg [15:0] mon1_reg;     // monitoring word one
   reg [15:0] mon2_reg;     // monitoring word two
   reg [3:1]  stk_reg;      // sticky error bits
   reg        sterr_next;   // access error decision
   reg        map_miss;     // index outside the map

   // bus decode: index in bits 13:2, rest must be zero
   wire [11:0] idx = PADDR_I[13:2];
   wire        aok = (PADDR_I[15:14] == 2'h0) && (PADDR_I[1:0] == 2'h0);
   wire [15:0] wd  = PWDATA_I[15:0];
   wire        wr  = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~PSLVERR_O;

   // out-of-range values are refused rather than clipped, so the
   // host learns of a bad setting at once
   always @* begin
      sterr_next = 1'b0;
      map_miss   = 1'b0;
      if (!aok)
         sterr_next = 1'b1;
      else begin
         case (idx)
            `DFSC_IX_ADDR: sterr_next = (wd == 16'h0000) ||
                                        (wd > {9'h0, `DFSC_MAX_ADDR});
            `DFSC_IX_POL:  sterr_next = (wd > {8'h0, `DFSC_POL_MAX}) &&
                                        (wd != {8'h0, `DFSC_POL_DEFER});
            `DFSC_IX_COMS, `DFSC_IX_FLDS, `DFSC_IX_CAPP, `DFSC_IX_WORD:
                           sterr_next = (wd > 16'h0001);
            `DFSC_IX_CBR:  sterr_next = (wd > 16'h0007);
            `DFSC_IX_SBR:  sterr_next = (wd > {12'h0, `DFSC_MAX_SBR});
            `DFSC_IX_FRM:  sterr_next = (wd > 16'h0003);
            `DFSC_IX_DLY:  sterr_next = (wd > {11'h0, `DFSC_MAX_DLY});
            `DFSC_IX_TMO:  sterr_next = (wd > {6'h0, `DFSC_MAX_TMO});
            `DFSC_IX_SVER, `DFSC_IX_CVER: sterr_next = 1'b1;
            `DFSC_IX_MON1, `DFSC_IX_MON2, `DFSC_IX_STAT:
                           sterr_next = 1'b0;
            default: begin
               sterr_next = 1'b1;
               map_miss   = 1'b1;
            end
         endcase
         // a read checks no value, only the index
         if (!PWRITE_I)
            sterr_next = map_miss;
      end
   end

   // apb answer: one wait state, data and error with pready
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0;
      end else begin
         PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & sterr_next;
         PRDATA_O  <= 32'h0;
         if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I) begin
            case (idx)
               `DFSC_IX_ADDR: PRDATA_O[6:0]  <= addr_reg;
               `DFSC_IX_POL:  PRDATA_O[7:0]  <= pol_reg;
               `DFSC_IX_COMS: PRDATA_O[0]    <= coms_reg;
               `DFSC_IX_FLDS: PRDATA_O[0]    <= flds_reg;
               `DFSC_IX_CAPP: PRDATA_O[0]    <= capp_reg;
               `DFSC_IX_CBR:  PRDATA_O[2:0]  <= cbr_reg;
               `DFSC_IX_SBR:  PRDATA_O[3:0]  <= sbr_reg;
               `DFSC_IX_FRM:  PRDATA_O[1:0]  <= frm_reg;
               `DFSC_IX_DLY:  PRDATA_O[4:0]  <= dly_reg;
               `DFSC_IX_TMO:  PRDATA_O[9:0]  <= tmo_reg;
               `DFSC_IX_WORD: PRDATA_O[0]    <= WORD_LOW_FIRST_O;
               `DFSC_IX_SVER: PRDATA_O[15:0] <= SER_VER;
               `DFSC_IX_CVER: PRDATA_O[15:0] <= CAN_VER;
               `DFSC_IX_MON1: PRDATA_O[15:0] <= mon1_reg;
               `DFSC_IX_MON2: PRDATA_O[15:0] <= mon2_reg;
               `DFSC_IX_STAT: PRDATA_O[3:0]  <= {stk_reg, LINK_TIMEOUT_O};
               default:       ;
            endcase
         end
      end
   end

   // serial line state shared with the register writes
   reg        rx_m_reg, rx_s_reg; // line synchroniser
   reg        set_ovr, set_par, set_frm;

   // register writes and sticky status, set beats clear
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         addr_reg <= `DFSC_RST_ADDR;
         pol_reg  <= `DFSC_RST_POL;
         coms_reg <= `DFSC_RST_COMS;
         flds_reg <= `DFSC_RST_FLDS;
         capp_reg <= `DFSC_RST_CAPP;
         cbr_reg  <= `DFSC_RST_CBR;
         sbr_reg  <= `DFSC_RST_SBR;
         frm_reg  <= `DFSC_RST_FRM;
         dly_reg  <= `DFSC_RST_DLY;
         tmo_reg  <= `DFSC_RST_TMO;
         mon1_reg <= 16'h0;
         mon2_reg <= 16'h0;
         stk_reg  <= 3'h0;
         WORD_LOW_FIRST_O <= `DFSC_RST_WORD;
      end else begin
         if (wr) begin
            case (idx)
               `DFSC_IX_ADDR: addr_reg <= wd[6:0];
               `DFSC_IX_POL:  pol_reg  <= wd[7:0];
               `DFSC_IX_COMS: coms_reg <= wd[0];
               `DFSC_IX_FLDS: flds_reg <= wd[0];
               `DFSC_IX_CAPP: capp_reg <= wd[0];
               `DFSC_IX_CBR:  cbr_reg  <= wd[2:0];
               // rate code takes effect at once
               `DFSC_IX_SBR:  sbr_reg  <= wd[3:0];
               `DFSC_IX_FRM:  frm_reg  <= wd[1:0];
               `DFSC_IX_DLY:  dly_reg  <= wd[4:0];
               `DFSC_IX_TMO:  tmo_reg  <= wd[9:0];
               `DFSC_IX_WORD: WORD_LOW_FIRST_O <= wd[0];
               `DFSC_IX_MON1: mon1_reg <= wd;
               `DFSC_IX_MON2: mon2_reg <= wd;
               default: ;
            endcase
         end
         // write one to clear; a new event in the same cycle wins
         stk_reg <= (stk_reg & ~((wr && idx == `DFSC_IX_STAT) ?
                     wd[3:1] : 3'h0)) | {set_frm, set_par, set_ovr};
      end
   end

   // settings that change only while the drive is stopped
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         STATION_ADDR_O <= `DFSC_RST_ADDR;
         CAN_KBPS_O     <= 10'd500;
         CAN_ENH_O      <= `DFSC_RST_CAPP;
      end else if (DRIVE_STOPPED_I) begin
         STATION_ADDR_O <= addr_reg;
         CAN_ENH_O      <= capp_reg;
         case (cbr_reg)
            3'h0:    CAN_KBPS_O <= 10'd20;
            3'h1:    CAN_KBPS_O <= 10'd50;
            3'h2:    CAN_KBPS_O <= 10'd100;
            3'h3:    CAN_KBPS_O <= 10'd125;
            3'h4:    CAN_KBPS_O <= 10'd250;
            3'h5:    CAN_KBPS_O <= 10'd500;
            default: CAN_KBPS_O <= 10'd1000;
         endcase
      end
   end

   // non-volatile save controls
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         SAVE_PARAM_O  <= 1'b1;
         SAVE_DICT_O   <= 1'b0;
         SAVE_PRE_OP_O <= 1'b0;
         COMM_SAVE_O   <= `DFSC_RST_COMS;
      end else begin
         COMM_SAVE_O <= coms_reg;
         SAVE_PARAM_O  <= (pol_reg == 8'h01) || (pol_reg == 8'h03);
         SAVE_DICT_O   <= (pol_reg == 8'h02) || (pol_reg == 8'h03);
         SAVE_PRE_OP_O <= (pol_reg == 8'h04);
         if (pol_reg == `DFSC_POL_DEFER) begin
            SAVE_PARAM_O <= flds_reg;
            SAVE_DICT_O  <= flds_reg;
         end
      end
   end

   // bit period in clocks; lowering CLK_HZ shortens simulation
   function [17:0] div_of;
      input [3:0] c;
      integer d;
      begin
         case (c)
            4'h0:    d = CLK_HZ / `DFSC_B0;
            4'h1:    d = CLK_HZ / `DFSC_B1;
            4'h2:    d = CLK_HZ / `DFSC_B2;
            4'h3:    d = CLK_HZ / `DFSC_B3;
            4'h4:    d = CLK_HZ / `DFSC_B4;
            4'h5:    d = CLK_HZ / `DFSC_B5;
            4'h6:    d = CLK_HZ / `DFSC_B6;
            4'h7:    d = CLK_HZ / `DFSC_B7;
            4'h8:    d = CLK_HZ / `DFSC_B8;
            default: d = CLK_HZ / `DFSC_B9;
         endcase
         div_of = d[17:0];
      end
   endfunction

   wire [17:0] div  = div_of(sbr_reg);
   wire        has_par  = (frm_reg == 2'h1) || (frm_reg == 2'h2);
   wire        odd_par  = (frm_reg == 2'h2);
   wire        two_stop = (frm_reg == 2'h0);

   // receiver
   reg [2:0]  rst_reg;   // receive state
   reg [17:0] rcnt_reg;  // bit timer, also gap timer when idle
   reg [2:0]  rbit_reg;  // data bit index
   reg [7:0]  rsh_reg;   // receive shifter
   reg        rpe_reg;   // parity error of this character
   reg [5:0]  gap_reg;   // idle bit times seen
   reg        infr_reg;  // inside a frame
   reg        match_reg; // frame is for this station
   reg        rdone;     // character complete, no error
   wire       rend = (rcnt_reg >= div - 18'h1);

   // two-stage line synchroniser
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         rx_m_reg <= 1'b1;
         rx_s_reg <= 1'b1;
      end else begin
         rx_m_reg <= RXD_I;
         rx_s_reg <= rx_m_reg;
      end
   end

   // receive state machine, mid-bit sampling
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         rst_reg  <= S_IDLE;
         rcnt_reg <= 18'h0;
         rbit_reg <= 3'h0;
         rsh_reg  <= 8'h0;
         rpe_reg  <= 1'b0;
         gap_reg  <= 6'h0;
         rdone    <= 1'b0;
         set_par  <= 1'b0;
         set_frm  <= 1'b0;
      end else begin
         rdone    <= 1'b0;
         set_par  <= 1'b0;
         set_frm  <= 1'b0;
         rcnt_reg <= rend ? 18'h0 : rcnt_reg + 18'h1;
         case (rst_reg)
            S_IDLE: begin
               if (!rx_s_reg) begin
                  rst_reg  <= S_START;
                  rcnt_reg <= 18'h0;
               end else if (rend && gap_reg != `DFSC_GAP_BITS)
                  gap_reg <= gap_reg + 6'h1;
            end
            S_START: begin
               // a start bit gone at half time was a glitch
               if (rcnt_reg == {1'b0, div[17:1]}) begin
                  rcnt_reg <= 18'h0;
                  rbit_reg <= 3'h0;
                  rpe_reg  <= 1'b0;
                  rst_reg  <= rx_s_reg ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               if (rend) begin
                  rsh_reg  <= {rx_s_reg, rsh_reg[7:1]};
                  rbit_reg <= rbit_reg + 3'h1;
                  if (rbit_reg == 3'h7)
                     rst_reg <= has_par ? S_PAR : S_STOP;
               end
            end
            S_PAR: begin
               if (rend) begin
                  rpe_reg <= (^rsh_reg ^ odd_par) != rx_s_reg;
                  rst_reg <= S_STOP;
               end
            end
            S_STOP: begin
               // only the first stop bit is checked on receive
               if (rend) begin
                  rst_reg <= S_IDLE;
                  gap_reg <= 6'h0;
                  set_frm <= ~rx_s_reg;
                  set_par <= rx_s_reg & rpe_reg;
                  rdone   <= rx_s_reg & ~rpe_reg;
               end
            end
            default: rst_reg <= S_IDLE;
         endcase
      end
   end

   // frame tracking, response delay and link timeout
   reg [15:0] ms_reg;    // millisecond prescaler
   reg [4:0]  dcnt_reg;  // reply delay left, ms
   reg        dly_on;    // reply delay running
   reg        open_reg;  // reply window open
   reg [9:0]  tcnt_reg;  // ms since last own frame
   wire       ms_tick  = (ms_reg == MS_CYC[15:0] - 16'h1);
   wire       frm_end  = infr_reg && (gap_reg == `DFSC_GAP_BITS);
   wire       first_b  = rdone && !infr_reg;

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         ms_reg    <= 16'h0;
         infr_reg  <= 1'b0;
         match_reg <= 1'b0;
         dcnt_reg  <= 5'h0;
         dly_on    <= 1'b0;
         open_reg  <= 1'b0;
         tcnt_reg  <= 10'h0;
         LINK_TIMEOUT_O <= 1'b0;
      end else begin
         ms_reg <= ms_tick ? 16'h0 : ms_reg + 16'h1;
         if (first_b) begin
            infr_reg <= 1'b1;
            match_reg <= (rsh_reg == {1'b0, STATION_ADDR_O});
            open_reg  <= 1'b0;
            dly_on    <= 1'b0;
         end else if (frm_end) begin
            infr_reg <= 1'b0;
            if (match_reg) begin
               // reply delay starts at frame end
               dcnt_reg <= dly_reg;
               dly_on   <= 1'b1;
            end
         end else if (dly_on) begin
            if (dcnt_reg == 5'h0) begin
               dly_on   <= 1'b0;
               open_reg <= 1'b1;
            end else if (ms_tick)
               dcnt_reg <= dcnt_reg - 5'h1;
         end
         if (frm_end && match_reg) begin
            tcnt_reg <= 10'h0;
            LINK_TIMEOUT_O <= 1'b0;
         end else begin
            if (ms_tick && tcnt_reg != `DFSC_MAX_TMO)
               tcnt_reg <= tcnt_reg + 10'h1;
            LINK_TIMEOUT_O <= (tmo_reg != 10'h0) && (tcnt_reg >= tmo_reg);
         end
      end
   end

   // two-entry receive buffer; a full buffer drops and flags
   wire       push = rdone && infr_reg && match_reg;
   wire       pop  = RX_VALID_O && RX_READY_I;
   reg [7:0]  skd_reg;   // second entry
   reg        skv_reg;   // second entry valid

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         RX_DATA_O  <= 8'h0;
         RX_VALID_O <= 1'b0;
         skd_reg    <= 8'h0;
         skv_reg    <= 1'b0;
         set_ovr    <= 1'b0;
      end else begin
         set_ovr <= 1'b0;
         if (pop) begin
            if (skv_reg) begin
               RX_DATA_O <= skd_reg;
               skv_reg   <= push;
               skd_reg   <= rsh_reg;
            end else begin
               RX_VALID_O <= push;
               RX_DATA_O  <= rsh_reg;
            end
         end else if (push) begin
            if (!RX_VALID_O) begin
               RX_VALID_O <= 1'b1;
               RX_DATA_O  <= rsh_reg;
            end else if (!skv_reg) begin
               skv_reg <= 1'b1;
               skd_reg <= rsh_reg;
            end else
               set_ovr <= 1'b1;
         end
      end
   end

   // transmitter, accepts bytes only while the reply window is open
   reg [2:0]  tst_reg;   // transmit state
   reg [17:0] tcyc_reg;  // bit timer
   reg [2:0]  tbit_reg;  // bit index, also stop count
   reg [7:0]  tsh_reg;   // transmit shifter
   reg        tpar_reg;  // parity of the character
   wire       tend = (tcyc_reg >= div - 18'h1);

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         tst_reg    <= S_IDLE;
         tcyc_reg   <= 18'h0;
         tbit_reg   <= 3'h0;
         tsh_reg    <= 8'h0;
         tpar_reg   <= 1'b0;
         TXD_O      <= 1'b1;
         TX_READY_O <= 1'b0;
      end else begin
         tcyc_reg <= tend ? 18'h0 : tcyc_reg + 18'h1;
         case (tst_reg)
            S_IDLE: begin
               TXD_O <= 1'b1;
               TX_READY_O <= open_reg & ~(TX_READY_O & TX_VALID_I);
               if (TX_READY_O && TX_VALID_I) begin
                  tsh_reg  <= TX_DATA_I;
                  tpar_reg <= ^TX_DATA_I ^ odd_par;
                  tcyc_reg <= 18'h0;
                  tst_reg  <= S_START;
                  TXD_O    <= 1'b0;
               end
            end
            S_START: begin
               if (tend) begin
                  tst_reg  <= S_DATA;
                  tbit_reg <= 3'h0;
                  TXD_O    <= tsh_reg[0];
               end
            end
            S_DATA: begin
               if (tend) begin
                  tbit_reg <= tbit_reg + 3'h1;
                  tsh_reg  <= {1'b0, tsh_reg[7:1]};
                  TXD_O    <= tsh_reg[1];
                  if (tbit_reg == 3'h7) begin
                     tst_reg  <= has_par ? S_PAR : S_STOP;
                     TXD_O    <= has_par ? tpar_reg : 1'b1;
                     tbit_reg <= 3'h0;
                  end
               end
            end
            S_PAR: begin
               if (tend) begin
                  tst_reg <= S_STOP;
                  TXD_O   <= 1'b1;
               end
            end
            S_STOP: begin
               if (tend) begin
                  tbit_reg <= tbit_reg + 3'h1;
                  if (tbit_reg == {2'h0, two_stop})
                     tst_reg <= S_IDLE;
               end
            end
            default: tst_reg <= S_IDLE;
         endcase
      end
   end
endmodule

// ### dv/dfsc_properties.sv
// Purpose: port checker of dfsc_top
// Assumes: one clock, synchronous reset active high
// Notes: bound to every dfsc_top instance
`timescale 1ns/1ps
module dfsc_props (
   input wire        CLK_I,
   input wire        SRST_I,
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PREADY_O,
   input wire [31:0] PRDATA_O,
   input wire        DRIVE_STOPPED_I,
   input wire [6:0]  STATION_ADDR_O,
   input wire [9:0]  CAN_KBPS_O,
   input wire        CAN_ENH_O,
   input wire        TX_READY_O,
   input wire        TX_VALID_I,
   input wire        RX_VALID_O,
   input wire        RX_READY_I,
   input wire [7:0]  RX_DATA_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready held");
   a_ready_delay: assert property (PSEL_I && PENABLE_I && !PREADY_O |=>
      PREADY_O) else $error("ready late");
   a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
      else $error("stray read data");
   a_addr_legal: assert property (STATION_ADDR_O != 7'h00)
      else $error("address zero");
   a_stop_hold: assert property (!DRIVE_STOPPED_I |=>
      $stable({STATION_ADDR_O, CAN_KBPS_O, CAN_ENH_O}))
      else $error("run change");
   a_can_legal: assert property (CAN_KBPS_O inside
      {10'd20, 10'd50, 10'd100, 10'd125, 10'd250, 10'd500, 10'd1000})
      else $error("bad can rate");
   a_tx_gap: assert property (TX_READY_O && TX_VALID_I |=>
      !TX_READY_O) else $error("ready kept");
   a_rx_hold: assert property (RX_VALID_O && !RX_READY_I |=>
      RX_VALID_O && $stable(RX_DATA_O)) else $error("rx byte lost");
   c_access: cover property (PREADY_O);
   c_rx_take: cover property (RX_VALID_O && RX_READY_I);
   c_tx_take: cover property (TX_READY_O && TX_VALID_I);
endmodule
bind dfsc_top dfsc_props i_dfsc_props (.*);

// ### dv/dfsc_host.sv
// Purpose: host controller side of the serial link
// Assumes: bench sets div, cycles per bit
// Notes: receiver ignores parity and stop bits
`timescale 1ns/1ps
module dfsc_host (
   input  wire clk_i,
   input  wire txd_i,
   output reg  rxd_o
);
   integer    div = 10; // cycles per bit
   integer    k, n;
   reg [10:0] fr;       // start, data, parity or stop, stop
   initial rxd_o = 1'b1; // line idles high
   task put(input [7:0] b, input [1:0] f);
      begin
         fr = {1'b1, f == 2'h0 || f == 2'h3 || (^b ^ (f == 2'h2)), b, 1'b0};
         n = (f == 2'h3) ? 10 : 11;
         for (k = 0; k < n; k = k + 1) begin
            rxd_o <= fr[k];
            repeat (div) @(posedge clk_i);
         end
      end
   endtask
   // lsb first, sampled mid bit
   task get(output [7:0] b);
      begin
         while (txd_i !== 1'b0) @(posedge clk_i);
         repeat (div / 2) @(posedge clk_i);
         for (k = 0; k < 8; k = k + 1) begin
            repeat (div) @(posedge clk_i);
            b[k] = txd_i;
         end
      end
   endtask
endmodule

// ### dv/tb.sv
// Purpose: self-checking bench of dfsc_top
// Assumes: one bit is 10 cycles at code 9, 1 ms is 50 cycles
// Notes: outputs are sampled on the falling edge after waits, on the rising edge in APB transfers and host serial steps
`timescale 1ns/1ps
module tb;
   reg         CLK_I = 0, SRST_I = 1, PSEL_I = 0, PENABLE_I = 0;
   reg         PWRITE_I = 0, DRIVE_STOPPED_I = 0, RX_READY_I = 0;
   reg         TX_VALID_I = 0, er;
   reg [15:0]  PADDR_I = 0;
   reg [31:0]  PWDATA_I = 0, rd;
   reg [7:0]   TX_DATA_I = 0, rb;
   reg [1:0]   f;
   wire [31:0] PRDATA_O;
   wire [7:0]  RX_DATA_O;
   wire [6:0]  STATION_ADDR_O;
   wire [9:0]  CAN_KBPS_O;
   wire        PREADY_O, PSLVERR_O, RXD_I, TXD_O, RX_VALID_O, TX_READY_O;
   wire        LINK_TIMEOUT_O, WORD_LOW_FIRST_O, CAN_ENH_O, COMM_SAVE_O;
   wire        SAVE_PARAM_O, SAVE_DICT_O, SAVE_PRE_OP_O;
   integer     err_count = 0, n_checks = 0, i;
   // index and reset value
   reg [27:0]  rt [0:14] = '{28'he000001, 28'he010001, 28'he030001,
      28'he040000, 28'he0a0000, 28'he0b0005, 28'he500009, 28'he510003,
      28'he520000, 28'he530000, 28'he540001, 28'he5a0000, 28'he5c0000,
      28'he610000, 28'he620000};
   // writes to refuse
   reg [27:0]  bt [0:10] = '{28'he000000, 28'he000080, 28'he50000a,
      28'he510004, 28'he520015, 28'he530259, 28'he0b0008, 28'he010005,
      28'he5a0001, 28'he020000, 28'he0a0002};
   reg [9:0]   kb [0:7] = '{10'd20, 10'd50, 10'd100, 10'd125, 10'd250,
      10'd500, 10'd1000, 10'd1000};
   reg [11:0]  pt [0:5] = '{12'h000, 12'h014, 12'h022, 12'h036, 12'h041,
      12'hff6};
   dfsc_top #(.CLK_HZ(1152000), .MS_CYC(50)) i_dfsc_top (.*);
   dfsc_host i_dfsc_host (.clk_i(CLK_I), .txd_i(TXD_O), .rxd_o(RXD_I));
   initial forever #12.5 CLK_I = ~CLK_I;
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // request held until ready is sampled
   task apb(input w, input [11:0] ix, input [15:0] d);
      begin
         @(posedge CLK_I);
         PSEL_I <= 1'b1;
         PWRITE_I <= w;
         PADDR_I <= {2'b00, ix, 2'b00};
         PWDATA_I <= {16'h0000, d};
         @(posedge CLK_I);
         PENABLE_I <= 1'b1;
         do @(posedge CLK_I); while (PREADY_O !== 1'b1);
         rd = PRDATA_O;
         er = PSLVERR_O;
         PSEL_I <= 1'b0;
         PENABLE_I <= 1'b0;
      end
   endtask
   task wr(input [11:0] ix, input [15:0] d, input e);
      begin
         apb(1'b1, ix, d);
         chk(er, e);
      end
   endtask
   task rdc(input [11:0] ix, input [15:0] e);
      begin
         apb(1'b0, ix, 16'h0000);
         chk(rd, {16'h0000, e});
      end
   endtask
   // compare a byte, then take it
   task rxchk(input [7:0] e);
      begin
         do @(negedge CLK_I); while (RX_VALID_O !== 1'b1);
         chk(RX_DATA_O, e);
         @(posedge CLK_I);
         RX_READY_I <= 1'b1;
         @(posedge CLK_I);
         RX_READY_I <= 1'b0;
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", n_checks, err_count);
         if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      err_count = err_count + 1;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge CLK_I);
      SRST_I <= 1'b0;
      for (i = 0; i < 15; i = i + 1)
         rdc(rt[i][27:16], rt[i][15:0]);
      for (i = 0; i < 11; i = i + 1)
         wr(bt[i][27:16], bt[i][15:0], 1'b1);
      for (i = 0; i < 15; i = i + 1)
         rdc(rt[i][27:16], rt[i][15:0]);
      wr(12'he00, 16'h007f, 1'b0);
      repeat (3) @(negedge CLK_I);
      chk(STATION_ADDR_O, 7'h01);
      @(posedge CLK_I);
      DRIVE_STOPPED_I <= 1'b1;
      repeat (2) @(negedge CLK_I);
      chk(STATION_ADDR_O, 7'h7f);
      for (i = 0; i < 8; i = i + 1) begin
         wr(12'he0b, i[15:0], 1'b0);
         repeat (2) @(negedge CLK_I);
         chk(CAN_KBPS_O, kb[i]);
      end
      wr(12'he0a, 16'h0001, 1'b0);
      wr(12'he03, 16'h0000, 1'b0);
      wr(12'he54, 16'h0000, 1'b0);
      wr(12'he04, 16'h0001, 1'b0);
      repeat (2) @(negedge CLK_I);
      chk({CAN_ENH_O, COMM_SAVE_O, WORD_LOW_FIRST_O}, 3'h4);
      for (i = 0; i < 6; i = i + 1) begin
         wr(12'he01, {8'h00, pt[i][11:4]}, 1'b0);
         repeat (2) @(negedge CLK_I);
         chk({SAVE_PARAM_O, SAVE_DICT_O, SAVE_PRE_OP_O}, pt[i][2:0]);
      end
      wr(12'he61, 16'hbeef, 1'b0);
      rdc(12'he61, 16'hbeef);
      wr(12'he51, 16'h0001, 1'b0);
      wr(12'he52, 16'h0001, 1'b0);
      i_dfsc_host.put(8'h7f, 2'h1);
      i_dfsc_host.put(8'ha5, 2'h1);
      i_dfsc_host.put(8'h3c, 2'h1);
      chk(TX_READY_O, 1'b0);
      rxchk(8'ha5);
      rxchk(8'h3c);
      do @(posedge CLK_I); while (TX_READY_O !== 1'b1);
      TX_DATA_I <= 8'h96;
      TX_VALID_I <= 1'b1;
      @(posedge CLK_I);
      TX_VALID_I <= 1'b0;
      i_dfsc_host.get(rb);
      chk(rb, 8'h96);
      chk(LINK_TIMEOUT_O, 1'b0);
      wr(12'he53, 16'h0002, 1'b0);
      repeat (200) @(negedge CLK_I);
      chk(LINK_TIMEOUT_O, 1'b1);
      @(posedge CLK_I);
      i_dfsc_host.put(8'h01, 2'h1);
      i_dfsc_host.put(8'h55, 2'h1);
      repeat (400) @(negedge CLK_I);
      chk(RX_VALID_O, 1'b0);
      wr(12'he50, 16'h0008, 1'b0);
      i_dfsc_host.div = 20;
      for (i = 0; i < 3; i = i + 1) begin
         f = i + (i > 0);
         wr(12'he51, {14'h0000, f}, 1'b0);
         i_dfsc_host.put(8'h7f, f);
         i_dfsc_host.put(8'hc0 | f, f);
         rxchk(8'hc0 | f);
         repeat (700) @(posedge CLK_I);
      end
      complete_run;
   end
endmodule
